//--- pkg/tcs_pkg.sv
package tcs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TCS_STATUS_RD_ADDR   = 8'h02;
  localparam logic [7:0] TCS_CONFIG_RD_ADDR   = 8'h03;
  localparam logic [7:0] TCS_CONFIG_WR_ADDR   = 8'h09;
  localparam logic [7:0] TCS_ONESHOT_WR_ADDR  = 8'h0F;
  localparam logic [7:0] TCS_CONFIG_RESET     = 8'h47;
  localparam logic [7:0] TCS_CONFIG_WR_MASK   = 8'h47;
  localparam logic [7:0] TCS_STATUS_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TCS_RATE_LSB      = 0;
  localparam int TCS_RATE_MSB      = 2;
  localparam int TCS_STANDBY_BIT   = 6;
  localparam int TCS_BUSY_BIT      = 7;
  localparam int TCS_NUM_CHANNELS  = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TCS_CLK_HZ        = 50_000_000;
  localparam int TCS_PASS_TIME_MS  = 60;
  localparam int TCS_PASS_CYCLES   = TCS_PASS_TIME_MS * (TCS_CLK_HZ / 1000);
  localparam int TCS_ONE_SEC_CYCLES = TCS_CLK_HZ;

  // ----------------------------------------------------------------
  // Rate codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TCS_RATE_1HZ  = 3'h3;
  localparam logic [2:0] TCS_RATE_2HZ  = 3'h4;
  localparam logic [2:0] TCS_RATE_4HZ  = 3'h5;
  localparam logic [2:0] TCS_RATE_8HZ  = 3'h6;
  localparam logic [2:0] TCS_RATE_16HZ = 3'h7;

  typedef enum logic [1:0] {
    TCS_IDLE    = 2'b00,
    TCS_CONVERT = 2'b01,
    TCS_WAIT    = 2'b10
  } tcs_state_t;

endpackage

//--- rtl/tcs_period_sel.sv
`timescale 1ns/10ps
module tcs_period_sel
  import tcs_pkg::*;
#(
  parameter int SEC_CYCLES = TCS_ONE_SEC_CYCLES
) (
  // Rate selection
  input  wire logic [2:0]  rate_code,
  // Pass period in cycles
  output logic      [31:0] period_cycles
);

  // Reserved codes fall back to the slowest rate, so a bad write never over-runs a pass.
  always_comb begin
    case (rate_code)
      TCS_RATE_2HZ:  period_cycles = 32'(SEC_CYCLES / 2);
      TCS_RATE_4HZ:  period_cycles = 32'(SEC_CYCLES / 4);
      TCS_RATE_8HZ:  period_cycles = 32'(SEC_CYCLES / 8);
      TCS_RATE_16HZ: period_cycles = 32'(SEC_CYCLES / 16);
      default:       period_cycles = 32'(SEC_CYCLES);
    endcase
  end

endmodule

//--- rtl/tcs_scheduler.sv
`timescale 1ns/10ps
// Function
// - Rate code is configuration bits 2 to 0.
// - Codes 3..7 give 1,2,4,8,16 passes per second; 0..2 reserved.
// - One pass covers three channels and lasts about 60 ms.
// - Configuration bit 6: 0 run mode, 1 standby.
// - In run mode passes start repeatedly at the selected rate.
// - In standby the front end is powered down except while a pass runs, no periodic passes.
// - Register access works in both modes at all times.
// - In standby a one-shot write starts exactly one pass.
// - After a one-shot pass the device returns to standby itself.
// - Status bit 7 is set while a pass is in progress.
// - Results update with a single one-cycle pulse at pass end.
module tcs_scheduler
  import tcs_pkg::*;
#(
  parameter int PASS_CYCLES = TCS_PASS_CYCLES,
  parameter int SEC_CYCLES  = TCS_ONE_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Front end control
  output logic            frontend_power,
  output logic            pass_active,
  output logic [1:0]      channel_sel,
  output logic            result_update
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  config_reg;
    tcs_state_t  state;
    logic [31:0] pass_cnt;
    logic [31:0] period_cnt;
    logic [1:0]  chan;
    logic        oneshot;
    logic        update;
    logic [7:0]  rdata;
  } tcs_regs_t;

  tcs_regs_t                    r;
  tcs_regs_t                    next_r;
  logic [31:0]                  period_cycles;
  logic                         standby;
  logic                         config_hit;
  logic                         oneshot_hit;
  logic [TCS_NUM_CHANNELS-1:0]  chan_done;

  localparam logic [31:0] CHAN_CYCLES = 32'(PASS_CYCLES / TCS_NUM_CHANNELS);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // A register strobe only counts when its address matches exactly.
  function automatic logic f_write_hit(
    input logic       wr,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return wr && (addr == target);
  endfunction

  // The converter is busy, and the front end powered, only in the convert state.
  function automatic logic f_converting(
    input tcs_state_t s
  );
    return (s == TCS_CONVERT);
  endfunction

  // Every pass starts the same way, whether periodic or one-shot.
  function automatic tcs_regs_t f_start_pass(
    input tcs_regs_t   cur,
    input logic [31:0] period
  );
    tcs_regs_t nxt;
    nxt            = cur;
    nxt.state      = TCS_CONVERT;
    nxt.pass_cnt   = 32'h0000_0000;
    nxt.chan       = 2'b00;
    nxt.period_cnt = period - 32'h0000_0001;
    return nxt;
  endfunction

  // Unmapped reads return zero, and reads never disturb any state.
  function automatic logic [7:0] f_read_data(
    input logic [7:0] addr,
    input logic [7:0] cfg,
    input logic       busy
  );
    logic [7:0] data;
    data = 8'h00;
    case (addr)
      TCS_STATUS_RD_ADDR: begin
        data               = TCS_STATUS_RESET;
        data[TCS_BUSY_BIT] = busy;
      end
      TCS_CONFIG_RD_ADDR: begin
        data = cfg;
      end
      default: begin
        data = 8'h00;
      end
    endcase
    return data;
  endfunction

  // ----------------------------------------------------------------
  // Channel boundaries
  // ----------------------------------------------------------------
  // One compare per channel marks the cycle at which that channel's slot ends.
  for (genvar i = 0; i < TCS_NUM_CHANNELS; i++) begin : g_chan
    assign chan_done[i] = (r.pass_cnt + 32'h0000_0001) >= (CHAN_CYCLES * 32'(i + 1));
  end

  // ----------------------------------------------------------------
  // Period select and decode
  // ----------------------------------------------------------------
  // Reserved rate codes fall back to one pass per second inside the period selector.
  tcs_period_sel #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_period (
    .rate_code     (r.config_reg[TCS_RATE_MSB:TCS_RATE_LSB]),
    .period_cycles (period_cycles)
  );

  assign standby     = r.config_reg[TCS_STANDBY_BIT];
  assign config_hit  = f_write_hit(reg_wr, reg_addr, TCS_CONFIG_WR_ADDR);
  assign oneshot_hit = f_write_hit(reg_wr, reg_addr, TCS_ONESHOT_WR_ADDR);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.update = 1'b0;
    // Configuration writes are served in every state and mode.
    if (config_hit) begin
      next_r.config_reg = reg_wdata & TCS_CONFIG_WR_MASK;
    end
    // A one-shot while converting is dropped, so a burst of writes still yields one pass.
    if (oneshot_hit && standby && !f_converting(r.state)) begin
      next_r.oneshot = 1'b1;
    end
    // The period counter runs from each pass start, so a pass longer than the period never overlaps.
    if (r.period_cnt != 32'h0000_0000) begin
      next_r.period_cnt = r.period_cnt - 32'h0000_0001;
    end
    case (r.state)
      TCS_IDLE: begin
        if (!standby || next_r.oneshot) begin
          next_r = f_start_pass(next_r, period_cycles);
        end
      end
      TCS_CONVERT: begin
        next_r.pass_cnt = r.pass_cnt + 32'h0000_0001;
        if (chan_done[r.chan] && r.chan != 2'(TCS_NUM_CHANNELS - 1)) begin
          next_r.chan = r.chan + 2'b01;
        end
        if (r.pass_cnt == 32'(PASS_CYCLES - 1)) begin
          next_r.update  = 1'b1;
          next_r.oneshot = 1'b0;
          next_r.state   = (standby || r.oneshot) ? TCS_IDLE : TCS_WAIT;
        end
      end
      TCS_WAIT: begin
        // A one-shot that arrives just as standby is entered starts its pass at once.
        if (standby && next_r.oneshot) begin
          next_r = f_start_pass(next_r, period_cycles);
        end else if (standby) begin
          next_r.state = TCS_IDLE;
        end else if (r.period_cnt == 32'h0000_0000) begin
          next_r = f_start_pass(next_r, period_cycles);
        end
      end
      default: begin
        next_r.state = TCS_IDLE;
      end
    endcase
    // Read data is registered: it appears one cycle after the read strobe.
    next_r.rdata = 8'h00;
    if (reg_rd) begin
      next_r.rdata = f_read_data(reg_addr, r.config_reg, f_converting(r.state));
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset is synchronous, so the defaults load on the first edge that sees rst_n low.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r.config_reg <= TCS_CONFIG_RESET;
      r.state      <= TCS_IDLE;
      r.pass_cnt   <= 32'h0000_0000;
      r.period_cnt <= 32'h0000_0000;
      r.chan       <= 2'b00;
      r.oneshot    <= 1'b0;
      r.update     <= 1'b0;
      r.rdata      <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata      = r.rdata;
  // The front end is powered only while a pass runs, which keeps standby current low.
  assign pass_active    = f_converting(r.state);
  assign frontend_power = f_converting(r.state);
  assign channel_sel    = r.chan;
  assign result_update  = r.update;

endmodule

//--- dv/tcs_scheduler_assertions.sv
`timescale 1ns/10ps
module tcs_scheduler_assertions
  import tcs_pkg::*;
#(
  parameter int PASS_CYCLES = TCS_PASS_CYCLES,
  parameter int SEC_CYCLES  = TCS_ONE_SEC_CYCLES
) (
  input wire logic       core_clk, rst_n, reg_wr, reg_rd,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic       frontend_power, pass_active, result_update,
  input wire logic [1:0] channel_sel
);
  logic [7:0] cfg;
  int         cnt;
  always_ff @(posedge core_clk) begin
    if (!rst_n) cfg <= TCS_CONFIG_RESET;
    else if (reg_wr && reg_addr == TCS_CONFIG_WR_ADDR) cfg <= reg_wdata & TCS_CONFIG_WR_MASK;
  end
  always_ff @(posedge core_clk) cnt <= (rst_n && pass_active) ? cnt + 1 : 0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  config_read_a: assert property (reg_rd && reg_addr == TCS_CONFIG_RD_ADDR |=> reg_rdata == $past(cfg))
    else $error("config readback wrong");
  busy_status_a: assert property (reg_rd && reg_addr == TCS_STATUS_RD_ADDR |=> reg_rdata[7] == $past(pass_active))
    else $error("busy bit wrong");
  unmapped_read_a: assert property (reg_rd && reg_addr != 8'h02 && reg_addr != 8'h03 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  oneshot_start_a: assert property (reg_wr && reg_addr == TCS_ONESHOT_WR_ADDR && cfg[6] && !pass_active
    |=> pass_active && frontend_power)
    else $error("one-shot did not start");
  standby_quiet_a: assert property (cfg[6] && !pass_active && !reg_wr |=> !pass_active)
    else $error("pass started in standby");
  power_follows_a: assert property (frontend_power == pass_active)
    else $error("front end power mismatch");
  power_wake_a: assert property ($rose(frontend_power)
    |-> !$past(cfg[6]) || $past(reg_wr && reg_addr == TCS_ONESHOT_WR_ADDR))
    else $error("front end woke without cause");
  pass_length_a: assert property (result_update |-> cnt == PASS_CYCLES)
    else $error("pass length wrong");
  last_channel_a: assert property (pass_active && cnt == PASS_CYCLES - 1 |-> channel_sel == 2'd2)
    else $error("last channel wrong");
  update_at_end_a: assert property ($fell(pass_active) |-> result_update ##1 !result_update)
    else $error("result update not at pass end");
  cover property (reg_wr && reg_addr == TCS_ONESHOT_WR_ADDR && cfg[6]);
  cover property (result_update && cfg[2:0] == 3'h7 && !cfg[6]);
  cover property (reg_rd && reg_addr == TCS_STATUS_RD_ADDR && pass_active);
endmodule
bind tcs_scheduler tcs_scheduler_assertions #(.PASS_CYCLES(PASS_CYCLES), .SEC_CYCLES(SEC_CYCLES)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frontend_power(frontend_power),
  .pass_active(pass_active), .result_update(result_update), .channel_sel(channel_sel));

//--- dv/tcs_host.sv
`timescale 1ns/10ps
module tcs_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge core_clk) #1;
    reg_wr = 1'b0;
  endtask
  // Data is taken before the strobe drops because it stands for one cycle only.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge core_clk) #1;
    d = reg_rdata;
    reg_rd = 1'b0;
  endtask
endmodule

//--- dv/tcs_scheduler_bench.sv
`timescale 1ns/10ps
module tcs_scheduler_bench;
  import tcs_pkg::*;
  localparam int PC = 30;
  localparam int SC = 960;
  logic       core_clk, rst_n, reg_wr, reg_rd, frontend_power, pass_active, result_update, hi;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [1:0] channel_sel;
  int         fail_count, comparisons, n;
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  tcs_scheduler #(.PASS_CYCLES(PC), .SEC_CYCLES(SC)) u_tcs_scheduler (.core_clk(core_clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .frontend_power(frontend_power), .pass_active(pass_active), .channel_sel(channel_sel),
    .result_update(result_update));
  tcs_host u_tcs_host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_lvl(input logic v);
    while (pass_active !== v) begin
      @(posedge core_clk) #1;
      n++;
      if (n > 3000) begin
        fail_count++;
        print_verdict();
      end
    end
  endtask
  task automatic t_regs();
    u_tcs_host.rd(TCS_CONFIG_RD_ADDR, d);
    check("config", d, TCS_CONFIG_RESET);
    u_tcs_host.rd(8'h05, d);
    check("unmapped", d, 8'h00);
    u_tcs_host.wr(TCS_CONFIG_WR_ADDR, 8'hFF);
    u_tcs_host.rd(TCS_CONFIG_RD_ADDR, d);
    check("config mask", d, TCS_CONFIG_WR_MASK);
    hi = 1'b0;
    repeat (SC + PC) begin
      @(posedge core_clk) #1;
      hi |= pass_active;
    end
    check("standby", hi, 1'b0);
  endtask
  // The second one-shot lands mid-pass and must not queue another pass.
  task automatic t_oneshot();
    u_tcs_host.wr(TCS_ONESHOT_WR_ADDR, 8'h00);
    u_tcs_host.wr(TCS_ONESHOT_WR_ADDR, 8'h00);
    u_tcs_host.rd(TCS_STATUS_RD_ADDR, d);
    check("busy", d[7], 1'b1);
    n = 0;
    repeat (3 * PC) begin
      @(posedge core_clk) #1;
      n += result_update;
    end
    check("passes", n, 1);
    u_tcs_host.rd(TCS_STATUS_RD_ADDR, d);
    check("idle", d, 8'h00);
  endtask
  task automatic t_rates();
    for (int c = 0; c < 8; c++) begin
      if (c == 1 || c == 2) continue;
      u_tcs_host.wr(TCS_CONFIG_WR_ADDR, 8'(c));
      n = 0;
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      n = 0;
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      check("period", n, c < 3 ? SC : SC >> (c - 3));
    end
  endtask
  // Reset lands during a periodic pass and must bring back the standby default.
  task automatic t_reset();
    n = 0;
    wait_lvl(1'b1);
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk) #1;
    rst_n = 1'b1;
    check("reset busy", pass_active, 1'b0);
    u_tcs_host.rd(TCS_CONFIG_RD_ADDR, d);
    check("reset config", d, TCS_CONFIG_RESET);
    hi = 1'b0;
    repeat (2 * PC) begin
      @(posedge core_clk) #1;
      hi |= pass_active;
    end
    check("reset standby", hi, 1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    fail_count = 0;
    comparisons = 0;
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_regs();
    t_oneshot();
    t_rates();
    t_reset();
    print_verdict();
  end
endmodule
